// ==== hdl/port_pin_pkg.sv ====
// Summary of operation
// - Analog port: eight input-only bits, feeding converter and timers
// - General port: nine bits, per-bit direction
// - Capture/CAN port: four bits, per-bit direction
// - Input-configured bidirectional bit keeps driver off, unless serial-channel mode or CAN routing sets its direction
// - Outputs selectable push-pull or open-drain
// - Bidirectional input threshold: TTL or special
// - CAN lines routable: bits 0/2 receive, 1/3 transmit
// - Capture/CAN bits double as channels 16-19
// - Analog bits 4,5 give timer 2/4 direction
// - Analog bits 6,7 give timer 2/4 count
// - Serial clock and data lines swap by master/slave
// - Bit 12 outputs high-byte enable or write strobe
// - Bit 15 clock/frequency out; 10,11 async serial
package port_pin_pkg;

  // ----------------------------------------------------------------
  // Port widths
  // ----------------------------------------------------------------
  localparam int ANALOG_WIDTH = 8;
  localparam int GBP_WIDTH = 9;
  localparam int CCP_WIDTH = 4;

  // ----------------------------------------------------------------
  // Analog input port bit positions
  // ----------------------------------------------------------------
  localparam int AIP_T2_UPDOWN = 4;
  localparam int AIP_T4_UPDOWN = 5;
  localparam int AIP_T2_COUNT = 6;
  localparam int AIP_T4_COUNT = 7;

  // ----------------------------------------------------------------
  // General port: packed index of each implemented pin
  // ----------------------------------------------------------------
  localparam int GBP_T3_UPDOWN = 0;   // Pin 4
  localparam int GBP_T3_COUNT = 1;    // Pin 6
  localparam int GBP_SSC_MISO = 2;    // Pin 8
  localparam int GBP_SSC_MOSI = 3;    // Pin 9
  localparam int GBP_ASYNC_TX = 4;    // Pin 10
  localparam int GBP_ASYNC_RX = 5;    // Pin 11
  localparam int GBP_HIGH_BYTE = 6;   // Pin 12
  localparam int GBP_SSC_CLK = 7;     // Pin 13
  localparam int GBP_CLK_OUT = 8;     // Pin 15

  // ----------------------------------------------------------------
  // Capture/CAN port bit positions
  // ----------------------------------------------------------------
  localparam int CCP_CAN_RX_A = 0;
  localparam int CCP_CAN_TX_A = 1;
  localparam int CCP_CAN_RX_B = 2;
  localparam int CCP_CAN_TX_B = 3;

  // ----------------------------------------------------------------
  // Reset values and latency
  // ----------------------------------------------------------------
  localparam logic PIN_RESET = 1'b0;
  localparam logic THRESHOLD_TTL = 1'b0;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;  // Sync plus output register

endpackage

// ==== hdl/pin_sync.sv ====
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  import port_pin_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;    // First stage, read by second stage only
    logic [WIDTH-1:0] stable;  // Second stage, safe to use
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_sync needs WIDTH of at least one");
  end

  // Shift pins through two stages
  always_comb
  begin
    next_state = state;
    next_state.meta = pin_i;
    next_state.stable = state.meta;
  end

  // Register the state
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign level_o = state.stable;

endmodule

// ==== hdl/pin_driver.sv ====
module pin_driver #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] value_i,       // Level to put out
  input wire logic [WIDTH-1:0] drive_i,       // 1 = output, 0 = input
  input wire logic [WIDTH-1:0] open_drain_i,  // 1 = open drain, 0 = push-pull
  output logic [WIDTH-1:0] pad_o,
  output logic [WIDTH-1:0] pad_oe_o
);
  import port_pin_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] out;  // Pad output level
    logic [WIDTH-1:0] oe;   // Pad driver enable
  } drv_state_t;

  drv_state_t state;
  drv_state_t next_state;

  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_driver needs WIDTH of at least one");
  end

  // Open drain pulls low only; a high request releases the pad
  always_comb
  begin
    next_state = state;
    next_state.oe = drive_i & ~(open_drain_i & value_i);
    next_state.out = value_i & ~open_drain_i;
  end

  // Register the state; driver off after reset
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pad_o = state.out;
  assign pad_oe_o = state.oe;

  // An open-drain pad is never actively driven high
  a_od_never_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (pad_oe_o & pad_o & $past(open_drain_i)) == '0) else $error("open drain drove high");

endmodule

// ==== hdl/port_pin_io_block.sv ====
module port_pin_io_block #(
  parameter int ANALOG_W = port_pin_pkg::ANALOG_WIDTH,
  parameter int GBP_W = port_pin_pkg::GBP_WIDTH,
  parameter int CCP_W = port_pin_pkg::CCP_WIDTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  // Analog input port pins
  input wire logic [ANALOG_W-1:0] analog_input_port_i,
  // General bidirectional port pins
  input wire logic [GBP_W-1:0] general_bidir_port_i,
  output logic [GBP_W-1:0] general_bidir_port_o,
  output logic [GBP_W-1:0] general_bidir_port_oe_o,
  // Capture/CAN port pins
  input wire logic [CCP_W-1:0] capture_can_port_i,
  output logic [CCP_W-1:0] capture_can_port_o,
  output logic [CCP_W-1:0] capture_can_port_oe_o,
  // Software control of general port
  input wire logic [GBP_W-1:0] gbp_data_i,
  input wire logic [GBP_W-1:0] gbp_dir_i,
  input wire logic [GBP_W-1:0] gbp_open_drain_i,
  input wire logic [GBP_W-1:0] gbp_alt_en_i,
  input wire logic gbp_special_threshold_i,
  // Software control of capture/CAN port
  input wire logic [CCP_W-1:0] ccp_data_i,
  input wire logic [CCP_W-1:0] ccp_dir_i,
  input wire logic [CCP_W-1:0] ccp_open_drain_i,
  input wire logic ccp_special_threshold_i,
  // Peripheral side: synchronous serial channel
  input wire logic ssc_master_i,
  input wire logic ssc_clock_out_i,
  input wire logic sync_serial_master_out_slave_in_i,
  input wire logic sync_serial_master_in_slave_out_i,
  // Peripheral side: asynchronous serial, bus, clock outputs
  input wire logic async_serial_transmit_i,
  input wire logic high_byte_enable_i,
  input wire logic high_byte_write_strobe_i,
  input wire logic write_high_mode_i,
  input wire logic system_clock_output_i,
  input wire logic programmable_frequency_output_i,
  input wire logic frequency_out_select_i,
  // Peripheral side: capture/compare and CAN
  input wire logic [CCP_W-1:0] capcomp_out_i,
  input wire logic [CCP_W-1:0] capcomp_out_en_i,
  input wire logic can_route_i,
  input wire logic can_pin_pair_i,
  input wire logic can_transmit_line_i,
  // Outputs to peripherals and software
  output logic [ANALOG_W-1:0] converter_channel_o,
  output logic [ANALOG_W-1:0] analog_port_read_o,
  output logic timer2_updown_input_o,
  output logic timer4_updown_input_o,
  output logic timer2_count_input_o,
  output logic timer4_count_input_o,
  output logic timer3_updown_input_o,
  output logic timer3_count_input_o,
  output logic ssc_clock_in_o,
  output logic sync_serial_master_in_slave_out_o,
  output logic sync_serial_master_out_slave_in_o,
  output logic async_serial_receive_o,
  output logic [CCP_W-1:0] capcomp_capture_o,
  output logic can_receive_line_o,
  output logic [GBP_W-1:0] gbp_read_o,
  output logic [CCP_W-1:0] ccp_read_o,
  output logic gbp_special_threshold_o,
  output logic ccp_special_threshold_o
);
  import port_pin_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Alternate-function positions are fixed, so widths cannot move
  if (ANALOG_W != ANALOG_WIDTH || GBP_W != GBP_WIDTH || CCP_W != CCP_WIDTH)
  begin : g_width_check
    $error("port widths must match the fixed pin map");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ANALOG_W-1:0] analog;   // Registered analog port levels
    logic [5:0] timer;             // Timer 2,4 updown/count; timer 3 updown/count
    logic [2:0] ssc_in;            // Clock in, master-in, slave-in
    logic async_rx;                // Async serial receive
    logic [CCP_W-1:0] capture;     // Capture inputs 16-19
    logic can_rx;                  // Selected CAN receive line
    logic [GBP_W-1:0] gbp_read;    // General port read value
    logic [CCP_W-1:0] ccp_read;    // Capture/CAN port read value
    logic [1:0] threshold;         // Special threshold selects
    logic [1:0] settle;            // Cycles since reset, saturating
  } io_state_t;

  io_state_t state;
  io_state_t next_state;

  // ----------------------------------------------------------------
  // Synchronised pin levels
  // ----------------------------------------------------------------
  logic [ANALOG_W-1:0] analog_sync;  // Analog port, synced
  logic [GBP_W-1:0] gbp_sync;        // General port, synced
  logic [CCP_W-1:0] ccp_sync;        // Capture/CAN port, synced

  pin_sync #(.WIDTH(ANALOG_W)) u_sync_analog (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(analog_input_port_i),
    .level_o(analog_sync)
  );

  pin_sync #(.WIDTH(GBP_W)) u_sync_gbp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(general_bidir_port_i),
    .level_o(gbp_sync)
  );

  pin_sync #(.WIDTH(CCP_W)) u_sync_ccp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(capture_can_port_i),
    .level_o(ccp_sync)
  );

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic [GBP_W-1:0] gbp_value;  // Level handed to the general port driver
  logic [GBP_W-1:0] gbp_drive;  // Effective direction of general port
  logic [CCP_W-1:0] ccp_value;  // Level handed to the capture/CAN driver
  logic [CCP_W-1:0] ccp_drive;  // Effective direction of capture/CAN port

  // Alternate functions replace the data latch; synchronous serial pins take direction from mode
  always_comb
  begin
    gbp_value = gbp_data_i;
    gbp_drive = gbp_dir_i;
    if (gbp_alt_en_i[GBP_SSC_MISO])
    begin
      gbp_value[GBP_SSC_MISO] = sync_serial_master_in_slave_out_i;
      gbp_drive[GBP_SSC_MISO] = ~ssc_master_i;
    end
    if (gbp_alt_en_i[GBP_SSC_MOSI])
    begin
      gbp_value[GBP_SSC_MOSI] = sync_serial_master_out_slave_in_i;
      gbp_drive[GBP_SSC_MOSI] = ssc_master_i;
    end
    if (gbp_alt_en_i[GBP_SSC_CLK])
    begin
      gbp_value[GBP_SSC_CLK] = ssc_clock_out_i;
      gbp_drive[GBP_SSC_CLK] = ssc_master_i;
    end
    if (gbp_alt_en_i[GBP_ASYNC_TX])
    begin
      gbp_value[GBP_ASYNC_TX] = async_serial_transmit_i;
    end
    if (gbp_alt_en_i[GBP_HIGH_BYTE])
    begin
      // Bus configuration picks strobe or enable
      gbp_value[GBP_HIGH_BYTE] = write_high_mode_i ? high_byte_write_strobe_i
                                                   : high_byte_enable_i;
    end
    if (gbp_alt_en_i[GBP_CLK_OUT])
    begin
      gbp_value[GBP_CLK_OUT] = frequency_out_select_i ? programmable_frequency_output_i
                                                      : system_clock_output_i;
    end
  end

  // Compare outputs, then CAN on top; CAN pins get fixed directions
  always_comb
  begin
    ccp_value = ccp_data_i;
    ccp_drive = ccp_dir_i;
    for (int b = 0; b < CCP_W; b++)
    begin
      if (capcomp_out_en_i[b])
      begin
        ccp_value[b] = capcomp_out_i[b];
      end
    end
    if (can_route_i)
    begin
      if (can_pin_pair_i)
      begin
        ccp_value[CCP_CAN_TX_B] = can_transmit_line_i;
        ccp_drive[CCP_CAN_TX_B] = 1'b1;
        ccp_drive[CCP_CAN_RX_B] = 1'b0;
      end
      else
      begin
        ccp_value[CCP_CAN_TX_A] = can_transmit_line_i;
        ccp_drive[CCP_CAN_TX_A] = 1'b1;
        ccp_drive[CCP_CAN_RX_A] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  pin_driver #(.WIDTH(GBP_W)) u_drv_gbp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .value_i(gbp_value),
    .drive_i(gbp_drive),
    .open_drain_i(gbp_open_drain_i),
    .pad_o(general_bidir_port_o),
    .pad_oe_o(general_bidir_port_oe_o)
  );

  pin_driver #(.WIDTH(CCP_W)) u_drv_ccp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .value_i(ccp_value),
    .drive_i(ccp_drive),
    .open_drain_i(ccp_open_drain_i),
    .pad_o(capture_can_port_o),
    .pad_oe_o(capture_can_port_oe_o)
  );

  // ----------------------------------------------------------------
  // Input distribution
  // ----------------------------------------------------------------
  // Every input listener sees the pin even while an alternate function owns it
  always_comb
  begin
    next_state = state;
    next_state.analog = analog_sync;
    next_state.timer[0] = analog_sync[AIP_T2_UPDOWN];
    next_state.timer[1] = analog_sync[AIP_T4_UPDOWN];
    next_state.timer[2] = analog_sync[AIP_T2_COUNT];
    next_state.timer[3] = analog_sync[AIP_T4_COUNT];
    next_state.timer[4] = gbp_sync[GBP_T3_UPDOWN];
    next_state.timer[5] = gbp_sync[GBP_T3_COUNT];
    next_state.ssc_in[0] = gbp_sync[GBP_SSC_CLK];
    next_state.ssc_in[1] = gbp_sync[GBP_SSC_MISO];
    next_state.ssc_in[2] = gbp_sync[GBP_SSC_MOSI];
    next_state.async_rx = gbp_sync[GBP_ASYNC_RX];
    next_state.capture = ccp_sync;
    next_state.can_rx = can_pin_pair_i ? ccp_sync[CCP_CAN_RX_B]
                                       : ccp_sync[CCP_CAN_RX_A];
    // Output bits read back their latch, input bits the pin
    next_state.gbp_read = (gbp_dir_i & gbp_data_i) | (~gbp_dir_i & gbp_sync);
    next_state.ccp_read = (ccp_dir_i & ccp_data_i) | (~ccp_dir_i & ccp_sync);
    next_state.threshold = {ccp_special_threshold_i, gbp_special_threshold_i};
    if (state.settle != SETTLE_CYCLES)
    begin
      next_state.settle = state.settle + 2'h1;
    end
  end

  // Register the state; threshold starts at TTL
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= '0;
      state.threshold <= {THRESHOLD_TTL, THRESHOLD_TTL};
      state.can_rx <= PIN_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign converter_channel_o = state.analog;
  assign analog_port_read_o = state.analog;
  assign timer2_updown_input_o = state.timer[0];
  assign timer4_updown_input_o = state.timer[1];
  assign timer2_count_input_o = state.timer[2];
  assign timer4_count_input_o = state.timer[3];
  assign timer3_updown_input_o = state.timer[4];
  assign timer3_count_input_o = state.timer[5];
  assign ssc_clock_in_o = state.ssc_in[0];
  assign sync_serial_master_in_slave_out_o = state.ssc_in[1];
  assign sync_serial_master_out_slave_in_o = state.ssc_in[2];
  assign async_serial_receive_o = state.async_rx;
  assign capcomp_capture_o = state.capture;
  assign can_receive_line_o = state.can_rx;
  assign gbp_read_o = state.gbp_read;
  assign ccp_read_o = state.ccp_read;
  assign gbp_special_threshold_o = state.threshold[0];
  assign ccp_special_threshold_o = state.threshold[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic settled;  // Pipeline holds only post-reset samples
  assign settled = (state.settle == SETTLE_CYCLES);

  a_gbp_input_hiz: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (general_bidir_port_oe_o & ~$past(gbp_drive)) == '0) else $error("general input bit driven");
  a_ccp_input_hiz: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (capture_can_port_oe_o & ~$past(ccp_drive)) == '0) else $error("capture input bit driven");
  a_push_pull_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    settled |-> ((~general_bidir_port_oe_o | (general_bidir_port_o ^ $past(gbp_value)))
    & $past(gbp_drive & ~gbp_open_drain_i)) == '0) else $error("push-pull bit not driven");
  a_analog_timers: assert property (@(posedge clk_i) disable iff (!resetn_i || !settled)
    {timer4_updown_input_o, timer2_updown_input_o} == $past(analog_input_port_i[5:4], 3))
    else $error("timer direction input wrong");
  a_analog_counts: assert property (@(posedge clk_i) disable iff (!resetn_i || !settled)
    {timer4_count_input_o, timer2_count_input_o} == $past(analog_input_port_i[7:6], 3))
    else $error("timer count input wrong");
  a_converter_feed: assert property (@(posedge clk_i) disable iff (!resetn_i || !settled)
    converter_channel_o == $past(analog_input_port_i, 3)) else $error("converter feed wrong");
  a_threshold_sel: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $changed(gbp_special_threshold_i) |=> gbp_special_threshold_o == $past(gbp_special_threshold_i))
    else $error("threshold select lagging");
  a_can_tx_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (can_route_i && !can_pin_pair_i && !ccp_open_drain_i[CCP_CAN_TX_A]) |=>
    (capture_can_port_oe_o[CCP_CAN_TX_A] && capture_can_port_o[CCP_CAN_TX_A] == $past(can_transmit_line_i)))
    else $error("CAN transmit not on pin");
  a_ssc_clk_dir: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (gbp_alt_en_i[GBP_SSC_CLK] && !ssc_master_i) |=> !general_bidir_port_oe_o[GBP_SSC_CLK])
    else $error("slave drove serial clock");
  a_read_input: assert property (@(posedge clk_i) disable iff (!resetn_i || !settled)
    ((gbp_read_o ^ $past(general_bidir_port_i, 3)) & ~$past(gbp_dir_i)) == '0)
    else $error("input bit read wrong");
  a_capture_feed: assert property (@(posedge clk_i) disable iff (!resetn_i || !settled)
    capcomp_capture_o == $past(capture_can_port_i, 3)) else $error("capture feed wrong");

endmodule

// ==== test/pin_world.sv ====
module pin_world (
  input wire logic [8:0] gbp_pad_i,
  input wire logic [8:0] gbp_oe_i,
  input wire logic [8:0] gbp_ext_i,
  input wire logic [3:0] ccp_pad_i,
  input wire logic [3:0] ccp_oe_i,
  input wire logic [3:0] ccp_ext_i,
  output logic [8:0] gbp_pin_o,
  output logic [3:0] ccp_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Driven pins follow the block; released ones show the outside level.
  // Open drain shows as oe high with a low pad, so no extra term needed.
  assign gbp_pin_o = (gbp_oe_i & gbp_pad_i) | (~gbp_oe_i & gbp_ext_i);
  assign ccp_pin_o = (ccp_oe_i & ccp_pad_i) | (~ccp_oe_i & ccp_ext_i);
endmodule

// ==== test/test_port_pin_io_block.sv ====
module test_port_pin_io_block;
  timeunit 1ns;
  timeprecision 1ns;
  import port_pin_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals (named as the block's ports)
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] analog_input_port_i = 8'h00;
  logic [7:0] converter_channel_o, analog_port_read_o;
  logic [8:0] general_bidir_port_i, general_bidir_port_o, general_bidir_port_oe_o, gbp_read_o;
  logic [8:0] gbp_data_i = '0, gbp_dir_i = '0, gbp_open_drain_i = '0, gbp_alt_en_i = '0, gbp_ext = '0;
  logic [3:0] capture_can_port_i, capture_can_port_o, capture_can_port_oe_o, ccp_read_o, capcomp_capture_o;
  logic [3:0] ccp_data_i = '0, ccp_dir_i = '0, ccp_open_drain_i = '0, ccp_ext = '0;
  logic [3:0] capcomp_out_i = '0, capcomp_out_en_i = '0;
  logic gbp_special_threshold_i = 1'b0, ccp_special_threshold_i = 1'b0, ssc_master_i = 1'b0;
  logic ssc_clock_out_i = 1'b0, sync_serial_master_out_slave_in_i = 1'b0, sync_serial_master_in_slave_out_i = 1'b0;
  logic async_serial_transmit_i = 1'b0, high_byte_enable_i = 1'b0, high_byte_write_strobe_i = 1'b0;
  logic write_high_mode_i = 1'b0, system_clock_output_i = 1'b0, programmable_frequency_output_i = 1'b0;
  logic frequency_out_select_i = 1'b0, can_route_i = 1'b0, can_pin_pair_i = 1'b0, can_transmit_line_i = 1'b0;
  logic timer2_updown_input_o, timer4_updown_input_o, timer2_count_input_o, timer4_count_input_o;
  logic timer3_updown_input_o, timer3_count_input_o, ssc_clock_in_o, async_serial_receive_o;
  logic sync_serial_master_in_slave_out_o, sync_serial_master_out_slave_in_o, can_receive_line_o;
  logic gbp_special_threshold_o, ccp_special_threshold_o;
  int n_errors = 0;
  int total_checks = 0;
  logic [7:0] av;
  logic [8:0] gv;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  port_pin_io_block u_dut (.*);
  // Outside world resolves the pads into the pin levels seen by the block
  pin_world u_world (.gbp_pad_i(general_bidir_port_o), .gbp_oe_i(general_bidir_port_oe_o),
    .gbp_ext_i(gbp_ext), .ccp_pad_i(capture_can_port_o), .ccp_oe_i(capture_can_port_oe_o),
    .ccp_ext_i(ccp_ext), .gbp_pin_o(general_bidir_port_i), .ccp_pin_o(capture_can_port_i));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inputs move at the falling edge; this waits whole cycles
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard: the run is far shorter than this
  initial
  begin
    #200us;
    n_errors++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(3);
    chk("gbp_oe_reset", 16'h0, general_bidir_port_oe_o);
    resetn_i = 1'b1;
    // Analog pins reach converter and timers after the 3-edge sync path
    for (int i = 0; i < 2; i++)
    begin
      av = i ? 8'ha5 : 8'h5a;
      analog_input_port_i = av;
      cyc(3);
      chk("converter", av, converter_channel_o);
      chk("analog_read", av, analog_port_read_o);
      chk("t2t4_updown", {av[5], av[4]}, {timer4_updown_input_o, timer2_updown_input_o});
      chk("t2t4_count", {av[7], av[6]}, {timer4_count_input_o, timer2_count_input_o});
    end
    // Push-pull then open drain on all nine outputs
    gbp_dir_i = 9'h1ff;
    gbp_data_i = 9'h155;
    cyc(1);
    chk("gbp_pp_oe", 16'h1ff, general_bidir_port_oe_o);
    chk("gbp_pp_out", 16'h155, general_bidir_port_o);
    chk("gbp_read_latch", 16'h155, gbp_read_o);
    gbp_open_drain_i = 9'h1ff;
    cyc(1);
    chk("gbp_od_oe", 16'h0aa, general_bidir_port_oe_o);
    chk("gbp_od_out", 16'h0, general_bidir_port_o);
    // Inputs: drivers off, reads and timer/serial inputs follow the pins
    // One extra cycle: the pads only release at the first edge
    gbp_dir_i = 9'h000;
    gbp_open_drain_i = 9'h000;
    for (int i = 0; i < 2; i++)
    begin
      gv = i ? 9'h156 : 9'h0a9;
      gbp_ext = gv;
      cyc(4);
      chk("gbp_in_oe", 16'h0, general_bidir_port_oe_o);
      chk("gbp_read_pin", gv, gbp_read_o);
      chk("t3_inputs", {gv[1], gv[0]}, {timer3_count_input_o, timer3_updown_input_o});
      chk("ssc_in", {gv[7], gv[3], gv[2]}, {ssc_clock_in_o, sync_serial_master_out_slave_in_o,
        sync_serial_master_in_slave_out_o});
      chk("async_rx", gv[5], async_serial_receive_o);
    end
    // Threshold selects, both ways round
    gbp_special_threshold_i = 1'b1;
    cyc(1);
    chk("thresholds", 16'h2, {gbp_special_threshold_o, ccp_special_threshold_o});
    gbp_special_threshold_i = 1'b0;
    ccp_special_threshold_i = 1'b1;
    cyc(1);
    chk("thresholds", 16'h1, {gbp_special_threshold_o, ccp_special_threshold_o});
    // Serial channel: data and clock directions swap with master mode
    gbp_alt_en_i = 9'h1ff;
    {ssc_clock_out_i, sync_serial_master_out_slave_in_i, sync_serial_master_in_slave_out_i} = 3'h7;
    ssc_master_i = 1'b1;
    cyc(1);
    chk("ssc_master_oe", 16'h088, general_bidir_port_oe_o);
    chk("ssc_master_out", 16'h088, general_bidir_port_o & general_bidir_port_oe_o);
    ssc_master_i = 1'b0;
    cyc(1);
    chk("ssc_slave_oe", 16'h004, general_bidir_port_oe_o);
    // Bus strobe, clock/frequency output and async transmit, every mode
    gbp_dir_i = 9'h150;
    high_byte_enable_i = 1'b1;
    programmable_frequency_output_i = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      write_high_mode_i = m[0];
      frequency_out_select_i = m[1];
      async_serial_transmit_i = m[0];
      cyc(1);
      chk("alt_out", {m[1], ~m[0], m[0]}, {general_bidir_port_o[8], general_bidir_port_o[6],
        general_bidir_port_o[4]});
      chk("alt_oe", 16'h7, {general_bidir_port_oe_o[8], general_bidir_port_oe_o[6],
        general_bidir_port_oe_o[4]});
    end
    // Compare outputs override the port value; capture sees the pins
    ccp_dir_i = 4'hf;
    capcomp_out_en_i = 4'hf;
    capcomp_out_i = 4'h9;
    cyc(1);
    chk("ccp_cmp_out", 16'h9, capture_can_port_o);
    chk("ccp_cmp_oe", 16'hf, capture_can_port_oe_o);
    ccp_dir_i = 4'h0;
    capcomp_out_en_i = 4'h0;
    ccp_ext = 4'h6;
    cyc(4);
    chk("ccp_in_oe", 16'h0, capture_can_port_oe_o);
    chk("capture", 16'h6, capcomp_capture_o);
    chk("ccp_read", 16'h6, ccp_read_o);
    // CAN on either pin pair; the unselected pins stay released
    can_route_i = 1'b1;
    can_transmit_line_i = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      can_pin_pair_i = p[0];
      ccp_ext = p ? 4'h4 : 4'h1;
      cyc(3);
      chk("can_tx_oe", p ? 16'h8 : 16'h2, capture_can_port_oe_o);
      chk("can_tx_out", p ? 16'h8 : 16'h2, capture_can_port_o & capture_can_port_oe_o);
      chk("can_rx", 16'h1, can_receive_line_o);
    end
    finish_test();
  end
endmodule
